// >>> lsims_pkg.sv
// Purpose: Shared constants and carrier types for the line-side rail mode select block.
// Assumes: The master clock of the channel logic is ref_clk_i.
// Notes: Every figure used by the design files is named here once.
package lsims_pkg;

   // Number of channels on the transceiver.
   localparam int unsigned LSIMS_NUM_CH = 8;

   // Consecutive high samples of the select pin that must be exceeded.
   localparam int unsigned LSIMS_SEL_RUN = 16;

   // Width of the run counter; it saturates one above the threshold.
   localparam int unsigned LSIMS_RUN_W = 5;

   // Depth of the transmit buffer per channel, in words.
   localparam int unsigned LSIMS_FIFO_DEPTH = 8;

   // Reset values of the mode and of the rail outputs.
   localparam logic LSIMS_MODE_RST = 1'h0;
   localparam logic LSIMS_RAIL_RST = 1'h0;

   // Signals delivered by the receive decoder of one channel, same clock domain.
   typedef struct packed {
      logic clk;   // Recovered receive clock.
      logic pos;   // Positive rail pulse.
      logic neg;   // Negative rail pulse.
      logic data;  // Decoded single-rail data.
      logic rx_violation_flag_out;   // Bipolar violation detected.
   } lsims_rx_type;

   // One transmit sample handed to the line encoder.
   typedef struct packed {
      logic unipolar;  // Mode in force when the sample was taken.
      logic pos;       // Positive rail, or single data in unipolar mode.
      logic neg;       // Negative rail; zero in unipolar mode.
   } lsims_tx_word_type;

   localparam int unsigned LSIMS_TX_W = $bits(lsims_tx_word_type);

endpackage

// >>> lsims_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes: DEPTH must be a power of two; storage is flip-flops.
`timescale 1ns/10ps
module lsims_fifo
   import lsims_pkg::*;
#(
   parameter int unsigned WIDTH = LSIMS_TX_W,
   parameter int unsigned DEPTH = LSIMS_FIFO_DEPTH
)
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointers carry one extra bit so that full and empty differ honestly.
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_bad_depth
         $error("lsims_fifo: DEPTH must be a power of two of at least 2.");
      end
   endgenerate

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   logic [AW:0] nxt_wr_ptr;
   logic [AW:0] nxt_rd_ptr;
   wire full_w = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
   wire empty_w = (wr_ptr_ff == rd_ptr_ff);
   wire push_w = in_valid_i && !full_w;
   wire pop_w = out_ready_i && !empty_w;

   // Handshake outputs are combinational; the head word is read by index.
   assign in_ready_o = !full_w;
   assign out_valid_o = !empty_w;
   assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];
   assign nxt_wr_ptr = push_w ? wr_ptr_ff + 1'h1 : wr_ptr_ff;
   assign nxt_rd_ptr = pop_w ? rd_ptr_ff + 1'h1 : rd_ptr_ff;

   // Pointer registers.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end
      else
      begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
      end
   end

   // Storage needs no reset; only words behind the write pointer are ever read.
   always_ff @(posedge ref_clk_i)
   begin
      if (push_w)
      begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
      end
   end

endmodule // lsims_fifo

// >>> lsims_top.sv
// Purpose: Per-channel choice between dual-rail and single-rail framer signalling.
// Assumes: ref_clk_i is the master clock; framer pins are asynchronous to it.
// Notes: The transmit negative-rail pin doubles as the mode select input.
//
// How it works
// - One mode per channel governs both its receive and its transmit pins.
// - Select pin low puts the channel in dual-rail mode; framer drives it low.
// - Single-rail mode only after more than 16 consecutive high samples.
// - Negative transmit rail and mode select share one pin; framer keeps it high.
// - In single-rail mode the negative receive pin reports bipolar violations.
`timescale 1ns/10ps
module lsims_top
   import lsims_pkg::*;
#(
   parameter int unsigned NUM_CH = LSIMS_NUM_CH,
   parameter int unsigned SEL_RUN = LSIMS_SEL_RUN,
   parameter int unsigned FIFO_DEPTH = LSIMS_FIFO_DEPTH
)
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [NUM_CH-1:0] tx_neg_rail_in_i,
   input wire logic [NUM_CH-1:0] tx_pos_rail_in_i,
   input wire logic [NUM_CH-1:0] tx_clock_in_i,
   input wire lsims_rx_type [NUM_CH-1:0] rx_core_i,
   output logic [NUM_CH-1:0] rx_pos_rail_out_o,
   output logic [NUM_CH-1:0] rx_neg_rail_out_o,
   output logic [NUM_CH-1:0] rx_clock_out_o,
   output logic [NUM_CH-1:0] unipolar_o,
   output lsims_tx_word_type [NUM_CH-1:0] tx_word_o,
   output logic [NUM_CH-1:0] tx_valid_o,
   input wire logic [NUM_CH-1:0] tx_ready_i,
   output logic [NUM_CH-1:0] tx_accept_o
);

   // The run counter must reach one above the threshold without wrapping.
   generate
      if (NUM_CH < 1 || SEL_RUN < 1 || SEL_RUN + 1 >= (1 << LSIMS_RUN_W))
      begin : g_bad_param
         $error("lsims_top: NUM_CH and SEL_RUN must fit the channel logic.");
      end
   endgenerate

   localparam logic [LSIMS_RUN_W-1:0] RUN_LIMIT = LSIMS_RUN_W'(SEL_RUN + 1);

   // Two-stage synchronisers for every framer pin; stage one feeds stage two only.
   logic [NUM_CH-1:0] neg_meta_ff;
   logic [NUM_CH-1:0] neg_sync_ff;
   logic [NUM_CH-1:0] pos_meta_ff;
   logic [NUM_CH-1:0] pos_sync_ff;
   logic [NUM_CH-1:0] tx_clock_in_meta_ff;
   logic [NUM_CH-1:0] tx_clock_in_sync_ff;
   logic [NUM_CH-1:0] tx_clock_in_prev_ff;

   // Select and negative-rail pin; its second stage feeds both the mode filter and data.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         neg_meta_ff <= '0;
         neg_sync_ff <= '0;
      end
      else
      begin
         neg_meta_ff <= tx_neg_rail_in_i;
         neg_sync_ff <= neg_meta_ff;
      end
   end

   // Positive-rail pin, delayed exactly like the negative rail so a word stays aligned.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         pos_meta_ff <= '0;
         pos_sync_ff <= '0;
      end
      else
      begin
         pos_meta_ff <= tx_pos_rail_in_i;
         pos_sync_ff <= pos_meta_ff;
      end
   end

   // Transmit clock pin; sharing the data's delay keeps its edge in the middle of a bit.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         tx_clock_in_meta_ff <= '0;
         tx_clock_in_sync_ff <= '0;
      end
      else
      begin
         tx_clock_in_meta_ff <= tx_clock_in_i;
         tx_clock_in_sync_ff <= tx_clock_in_meta_ff;
      end
   end

   // Previous transmit clock level, used to find its rising edges.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         tx_clock_in_prev_ff <= '0;
      end
      else
      begin
         tx_clock_in_prev_ff <= tx_clock_in_sync_ff;
      end
   end

   // Rising edge of each transmit clock; data and clock share the same sync delay.
   wire [NUM_CH-1:0] tx_clock_in_rise_w = tx_clock_in_sync_ff & ~tx_clock_in_prev_ff;

   // Receive outputs and mode are registered so the pins never glitch on a switch.
   logic [NUM_CH-1:0] unipolar_ff;
   logic [NUM_CH-1:0] rx_pos_ff;
   logic [NUM_CH-1:0] rx_neg_ff;
   logic [NUM_CH-1:0] rx_clk_ff;
   logic [NUM_CH-1:0] nxt_unipolar;
   logic [NUM_CH-1:0] nxt_rx_pos;
   logic [NUM_CH-1:0] nxt_rx_neg;
   logic [NUM_CH-1:0] fifo_in_ready;
   lsims_tx_word_type [NUM_CH-1:0] sample_word;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : g_ch
         logic [LSIMS_RUN_W-1:0] run_ff;
         logic [LSIMS_RUN_W-1:0] nxt_run;

         // The run counter clears on any low sample and saturates at the limit.
         assign nxt_run = !neg_sync_ff[ch] ? '0 :
                          (run_ff == RUN_LIMIT) ? run_ff :
                          LSIMS_RUN_W'(run_ff + 1'h1);

         always_ff @(posedge ref_clk_i)
         begin
            if (srst_i)
            begin
               run_ff <= '0;
            end
            else
            begin
               run_ff <= nxt_run;
            end
         end

         // The mode falls back the cycle a low is seen and rises only past the threshold.
         // A framer that holds the pin high in dual-rail use will flip the mode; the
         // pin is shared, so that cost is the framer's to avoid.
         assign nxt_unipolar[ch] = (nxt_run == RUN_LIMIT);

         // Receive pin selection: one mode bit steers both directions of the channel.
         assign nxt_rx_pos[ch] = unipolar_ff[ch] ? rx_core_i[ch].data
                                                 : rx_core_i[ch].pos;
         assign nxt_rx_neg[ch] = unipolar_ff[ch] ? rx_core_i[ch].rx_violation_flag_out
                                                 : rx_core_i[ch].neg;

         // Transmit sample: in single-rail mode the shared pin is a select, not data.
         assign sample_word[ch].unipolar = unipolar_ff[ch];
         assign sample_word[ch].pos = pos_sync_ff[ch];
         assign sample_word[ch].neg = neg_sync_ff[ch] & ~unipolar_ff[ch];

         // Each channel buffers transmit samples until the line encoder takes them.
         // A sample that meets a full buffer is dropped; tx_accept_o low shows it.
         lsims_fifo #(
            .WIDTH(LSIMS_TX_W),
            .DEPTH(FIFO_DEPTH)
         ) u_tx_fifo (
            .ref_clk_i(ref_clk_i),
            .srst_i(srst_i),
            .in_data_i(sample_word[ch]),
            .in_valid_i(tx_clock_in_rise_w[ch]),
            .in_ready_o(fifo_in_ready[ch]),
            .out_data_o(tx_word_o[ch]),
            .out_valid_o(tx_valid_o[ch]),
            .out_ready_i(tx_ready_i[ch])
         );
      end
   endgenerate

   // Receive clock passes through in both modes, delayed like the data.
   wire [NUM_CH-1:0] rx_core_clk_w;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : g_rclk
         assign rx_core_clk_w[ch] = rx_core_i[ch].clk;
      end
   endgenerate

   // Mode register; it resets to dual-rail so no channel starts on a stale select.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         unipolar_ff <= {NUM_CH{LSIMS_MODE_RST}};
      end
      else
      begin
         unipolar_ff <= nxt_unipolar;
      end
   end

   // Receive output registers; one flop stage keeps the pins clean across a mode switch.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         rx_pos_ff <= {NUM_CH{LSIMS_RAIL_RST}};
         rx_neg_ff <= {NUM_CH{LSIMS_RAIL_RST}};
         rx_clk_ff <= {NUM_CH{LSIMS_RAIL_RST}};
      end
      else
      begin
         rx_pos_ff <= nxt_rx_pos;
         rx_neg_ff <= nxt_rx_neg;
         rx_clk_ff <= rx_core_clk_w;
      end
   end

   // Output drive.
   assign unipolar_o = unipolar_ff;
   assign rx_pos_rail_out_o = rx_pos_ff;
   assign rx_neg_rail_out_o = rx_neg_ff;
   assign rx_clock_out_o = rx_clk_ff;
   assign tx_accept_o = fifo_in_ready;

endmodule // lsims_top

// >>> lsims_checker.sv
// Purpose: Port-level timing checks of the rail mode select block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Mode timing is watched on channel 0 only.
`timescale 1ns/10ps
module lsims_checker
   import lsims_pkg::*;
#(
   parameter int unsigned NUM_CH = LSIMS_NUM_CH,
   parameter int unsigned SEL_RUN = LSIMS_SEL_RUN
)
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [NUM_CH-1:0] tx_neg_rail_in_i,
   input wire lsims_rx_type [NUM_CH-1:0] rx_core_i,
   input wire logic [NUM_CH-1:0] rx_pos_rail_out_o,
   input wire logic [NUM_CH-1:0] rx_neg_rail_out_o,
   input wire logic [NUM_CH-1:0] unipolar_o,
   input wire lsims_tx_word_type [NUM_CH-1:0] tx_word_o,
   input wire logic [NUM_CH-1:0] tx_valid_o,
   input wire logic [NUM_CH-1:0] tx_ready_i,
   input wire logic [NUM_CH-1:0] tx_accept_o
);
   logic [7:0] run_ff;
   logic exp_pos;
   logic exp_neg;
   // Counts consecutive high pin samples; it saturates so a held pin never wraps.
   always_ff @(posedge ref_clk_i)
      if (srst_i || !tx_neg_rail_in_i[0])
         run_ff <= 8'h00;
      else if (run_ff != 8'hff)
         run_ff <= run_ff + 8'h01;
   // Receive pin contents expected one cycle later.
   assign exp_pos = unipolar_o[0] ? rx_core_i[0].data : rx_core_i[0].pos;
   assign exp_neg = unipolar_o[0] ? rx_core_i[0].rx_violation_flag_out : rx_core_i[0].neg;
   default clocking dc @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   mode_set_a: assert property (run_ff > SEL_RUN + 2 |-> unipolar_o[0])
      else $error("single-rail mode late");
   mode_rise_a: assert property ($rose(unipolar_o[0]) |-> $past(run_ff, 2) > SEL_RUN)
      else $error("single-rail mode early");
   mode_clear_a: assert property (!tx_neg_rail_in_i[0] |-> ##4 !unipolar_o[0])
      else $error("dual-rail mode not restored");
   rx_pos_a: assert property (!$past(srst_i) |-> rx_pos_rail_out_o[0] == $past(exp_pos))
      else $error("receive positive pin wrong");
   rx_neg_a: assert property (!$past(srst_i) |-> rx_neg_rail_out_o[0] == $past(exp_neg))
      else $error("receive negative pin wrong");
   tx_neg_a: assert property (tx_valid_o[0] && tx_word_o[0].unipolar |-> !tx_word_o[0].neg)
      else $error("negative rail set in single-rail word");
   tx_hold_a: assert property (tx_valid_o[0] && !tx_ready_i[0] |=>
      tx_valid_o[0] && $stable(tx_word_o[0]))
      else $error("head word not held");
   rst_val_a: assert property (@(posedge ref_clk_i) disable iff (1'b0) srst_i |=>
      !unipolar_o && !tx_valid_o && &tx_accept_o)
      else $error("reset values wrong");
endmodule // lsims_checker
bind lsims_top lsims_checker #(.NUM_CH(NUM_CH), .SEL_RUN(SEL_RUN)) lsims_checker_i (.*);

// >>> lsims_framer_model.sv
// Purpose: Behavioural framer on the far side of all eight channels.
// Assumes: One transmit clock of 200 ns period serves every channel.
// Notes: Data moves on the falling clock edge so it is settled at the rising edge.
`timescale 1ns/10ps
module lsims_framer_model
(
   input wire logic [7:0] mode_i,
   output logic tx_clock_in_o,
   output logic [7:0] tx_pos_rail_in_o,
   output logic [7:0] tx_neg_rail_in_o
);
   logic [1:0] beat_ff = 2'h0;
   // A line clock runs free, so it does not pause between frames.
   initial tx_clock_in_o = 1'b0;
   always #100 tx_clock_in_o = ~tx_clock_in_o;
   always @(negedge tx_clock_in_o) beat_ff <= beat_ff + 2'h1;
   assign tx_pos_rail_in_o = {8{beat_ff[0]}} ^ 8'h5a;
   // Held high to ask for single-rail; dual-rail highs last one clock period.
   assign tx_neg_rail_in_o = mode_i | {8{&beat_ff}};
endmodule // lsims_framer_model

// >>> lsims_top_tb_top.sv
// Purpose: Self-checking bench for the rail mode select block.
// Assumes: Select threshold lowered to 10 samples to keep runs short.
// Notes: The bench may take over the channel 0 select pin for exact runs.
`timescale 1ns/10ps
module lsims_top_tb_top
   import lsims_pkg::*;
;
   localparam int unsigned RUN = 10;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ovr = 1'b1;
   logic ovr_v = 1'b0;
   logic [7:0] mode = 8'h00;
   logic [7:0] tx_ready_i = 8'hff;
   lsims_rx_type [7:0] rx_core_i = '0;
   logic tx_clock_in;
   logic [7:0] mneg, tx_neg_rail_in_i, tx_pos_rail_in_i, tx_clock_in_i;
   logic [7:0] rx_pos_rail_out_o, rx_neg_rail_out_o, rx_clock_out_o;
   logic [7:0] unipolar_o, tx_valid_o, tx_accept_o;
   lsims_tx_word_type [7:0] tx_word_o;
   int err_total = 0;
   int checks = 0;
   // Channel 0 select pin comes from the framer or from the bench.
   assign tx_neg_rail_in_i = {mneg[7:1], ovr ? ovr_v : mneg[0]};
   assign tx_clock_in_i = {8{tx_clock_in}};
   always #12.5 ref_clk_i = ~ref_clk_i;
   lsims_framer_model lsims_framer_model_i (.mode_i(mode), .tx_clock_in_o(tx_clock_in),
      .tx_pos_rail_in_o(tx_pos_rail_in_i), .tx_neg_rail_in_o(mneg));
   lsims_top #(.SEL_RUN(RUN)) lsims_top_i (.*);
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #2;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic t_reset();
      srst_i = 1'b1;
      cyc(2);
      srst_i = 1'b0;
      cmp(unipolar_o, 8'h00);
      cmp(tx_valid_o, 8'h00);
      cmp(tx_accept_o, 8'hff);
      $display("reset done");
   endtask
   task automatic t_run(input int n, input logic exp);
      logic seen;
      seen = 1'b0;
      ovr_v = 1'b1;
      cyc(n);
      ovr_v = 1'b0;
      repeat (6)
      begin
         cyc(1);
         seen = seen | unipolar_o[0];
      end
      cmp({7'h0, seen}, {7'h0, exp});
      cmp({7'h0, unipolar_o[0]}, 8'h00);
      $display("run of %0d done", n);
   endtask
   task automatic t_rx(input logic [7:0] m);
      logic [7:0] ep, en, ek;
      mode = m;
      cyc(RUN + 8);
      cmp(unipolar_o, m);
      for (int p = 0; p < 4; p++)
      begin
         for (int c = 0; c < 8; c++)
         begin
            rx_core_i[c] = lsims_rx_type'(5'(c * 7 + p * 9));
            ep[c] = m[c] ? rx_core_i[c].data : rx_core_i[c].pos;
            en[c] = m[c] ? rx_core_i[c].rx_violation_flag_out : rx_core_i[c].neg;
            ek[c] = rx_core_i[c].clk;
         end
         cyc(1);
         cmp(rx_pos_rail_out_o, ep);
         cmp(rx_neg_rail_out_o, en);
         cmp(rx_clock_out_o, ek);
      end
      $display("receive mode %h done", m);
   endtask
   // The encoder stalls until the buffer refuses, then drains it.
   task automatic t_tx(input logic m);
      int n;
      int ones;
      logic prev;
      mode = {8{m}};
      cyc(RUN + 40);
      tx_ready_i = 8'h00;
      for (n = 0; n < 150 && tx_accept_o[0] !== 1'b0; n++)
         cyc(1);
      cmp({7'h0, tx_accept_o[0]}, 8'h00);
      if (n >= 150) test_done();
      tx_ready_i = 8'hff;
      prev = ~tx_word_o[0].pos;
      ones = 0;
      for (n = 0; n < 40 && tx_valid_o[0] === 1'b1; n++)
      begin
         cmp({7'h0, tx_word_o[0].unipolar}, {7'h0, m});
         if (m) cmp({7'h0, tx_word_o[0].neg}, 8'h00);
         cmp({7'h0, tx_word_o[0].pos}, {7'h0, ~prev});
         prev = tx_word_o[0].pos;
         ones += tx_word_o[0].neg;
         cyc(1);
      end
      if (!m) cmp({7'h0, ones >= 2}, 8'h01);
      cmp({7'h0, n >= 8 && n < 40}, 8'h01);
      if (n >= 40) test_done();
      $display("transmit mode %0d done", m);
   endtask
   initial
   begin
      t_reset();
      t_run(RUN, 1'b0);
      t_run(RUN + 1, 1'b1);
      ovr = 1'b0;
      t_rx(8'h00);
      t_rx(8'h3c);
      t_rx(8'hff);
      t_tx(1'b0);
      t_tx(1'b1);
      tx_ready_i = 8'h00;
      mode = 8'h00;
      cyc(30);
      t_reset();
      test_done();
   end
endmodule // lsims_top_tb_top
